// *** rtl/dosr_pkg.sv ***
// constants and carrier types for the digital output source router
// assumes a single drive clock; parameter writes arrive as one-cycle requests
package dosr_pkg;
	localparam int DOSR_NUM_DO = 5;
	localparam int DOSR_DATA_W = 16;
	localparam logic [15:0] DOSR_ADDR_SRC_SEL = 16'h0416;
	localparam logic [15:0] DOSR_ADDR_NONOP_MASK = 16'h0417;
	localparam logic [15:0] DOSR_SRC_SEL_RST = 16'h0000;
	localparam logic [15:0] DOSR_NONOP_MASK_RST = 16'h0000;
	localparam logic [15:0] DOSR_FORCED_RST = 16'h0000;
	localparam logic [15:0] DOSR_VALUE_MAX = 16'h001F;
	localparam logic [15:0] DOSR_RD_UNMAPPED = 16'h0000;
	localparam logic DOSR_LEVEL_OFF = 1'b0;

	typedef struct packed {
		logic valid;
		logic from_comm;
		logic to_forced;
		logic [15:0] addr;
		logic [15:0] data;
	} dosr_wr_type;
endpackage

// *** rtl/dosr_router.sv ***
// digital output source router: per-terminal choice of drive function or forced bit
// assumes all inputs synchronous to clk; writes are one-cycle requests
`timescale 1ns/10ps

module dosr_router import dosr_pkg::*; #(
	parameter int N_OUT = DOSR_NUM_DO
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// parameter access
	input wire dosr_wr_type param_wr,
	input wire logic [15:0] rd_addr,
	output logic [15:0] rd_data_r,
	output logic wr_rejected_r,
	// drive side
	input wire logic [N_OUT-1:0] func_result,
	input wire logic [N_OUT-1:0] polarity,
	input wire logic link_operational_state,
	// terminals
	output logic [N_OUT-1:0] digital_output
);
	logic [15:0] sel_r, sel_nxt;
	logic [15:0] mask_r, mask_nxt;
	logic [15:0] forced_r, forced_nxt;
	logic [15:0] rd_data_nxt;
	logic rej_nxt;
	logic op_r;
	logic [N_OUT-1:0] do_r, do_nxt;

	// register writes and read mux
	always_comb begin
		sel_nxt = sel_r;
		mask_nxt = mask_r;
		forced_nxt = forced_r;
		rej_nxt = 1'b0;
		if (param_wr.valid) begin
			if (param_wr.to_forced) begin
				if (param_wr.from_comm)
					forced_nxt = param_wr.data;
				else
					rej_nxt = 1'b1;
			end else if (param_wr.addr == DOSR_ADDR_SRC_SEL) begin
				if (param_wr.data <= DOSR_VALUE_MAX)
					sel_nxt = param_wr.data;
				else
					rej_nxt = 1'b1;
			end else if (param_wr.addr == DOSR_ADDR_NONOP_MASK) begin
				if (param_wr.data <= DOSR_VALUE_MAX)
					mask_nxt = param_wr.data;
				else
					rej_nxt = 1'b1;
			end else begin
				rej_nxt = 1'b1;
			end
		end
		if (rd_addr == DOSR_ADDR_SRC_SEL)
			rd_data_nxt = sel_r;
		else if (rd_addr == DOSR_ADDR_NONOP_MASK)
			rd_data_nxt = mask_r;
		else
			rd_data_nxt = DOSR_RD_UNMAPPED;
	end

	// per-terminal routing
	genvar n;
	generate
		for (n = 0; n < N_OUT; n++) begin : g_out
			logic active;
			assign active = sel_r[n] ? forced_r[n] : func_result[n];
			assign do_nxt[n] = (sel_r[n] && !op_r) ?
				(mask_r[n] ? DOSR_LEVEL_OFF : do_r[n]) :
				(active ^ polarity[n]);
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sel_r <= DOSR_SRC_SEL_RST;
			mask_r <= DOSR_NONOP_MASK_RST;
			forced_r <= DOSR_FORCED_RST;
			rd_data_r <= DOSR_RD_UNMAPPED;
			wr_rejected_r <= 1'b0;
			op_r <= 1'b0;
			do_r <= '0;
		end else begin
			sel_r <= sel_nxt;
			mask_r <= mask_nxt;
			forced_r <= forced_nxt;
			rd_data_r <= rd_data_nxt;
			wr_rejected_r <= rej_nxt;
			op_r <= link_operational_state;
			do_r <= do_nxt;
		end
	end

	assign digital_output = do_r;

	// checks
	property p_func_route;
		@(posedge clk) disable iff (!reset_n)
		!sel_r[0] |=> digital_output[0] == ($past(func_result[0]) ^ $past(polarity[0]));
	endproperty
	a_func_route: assert property (p_func_route) else $error("function route wrong");

	property p_forced_route;
		@(posedge clk) disable iff (!reset_n)
		(sel_r[2] && op_r) |=> digital_output[2] == ($past(forced_r[2]) ^ $past(polarity[2]));
	endproperty
	a_forced_route: assert property (p_forced_route) else $error("forced route wrong");

	property p_sel_range;
		@(posedge clk) disable iff (!reset_n)
		(param_wr.valid && !param_wr.to_forced && param_wr.addr == DOSR_ADDR_SRC_SEL)
		|=> (sel_r == ($past(param_wr.data) <= DOSR_VALUE_MAX ? $past(param_wr.data)
			: $past(sel_r))) && (wr_rejected_r == ($past(param_wr.data) > DOSR_VALUE_MAX));
	endproperty
	a_sel_range: assert property (p_sel_range) else $error("select write wrong");

	property p_forced_local;
		@(posedge clk) disable iff (!reset_n)
		(param_wr.valid && param_wr.to_forced && !param_wr.from_comm)
		|=> $stable(forced_r) && wr_rejected_r;
	endproperty
	a_forced_local: assert property (p_forced_local) else $error("local forced write taken");

	property p_nonop_hold;
		@(posedge clk) disable iff (!reset_n)
		(sel_r[1] && !op_r && !mask_r[1]) |=> $stable(digital_output[1]);
	endproperty
	a_nonop_hold: assert property (p_nonop_hold) else $error("non-op output changed");

	property p_nonop_off;
		@(posedge clk) disable iff (!reset_n)
		(sel_r[4] && !op_r && mask_r[4]) |=> digital_output[4] == DOSR_LEVEL_OFF;
	endproperty
	a_nonop_off: assert property (p_nonop_off) else $error("non-op output not off");

	property p_polarity;
		@(posedge clk) disable iff (!reset_n)
		(!sel_r[3] && polarity[3] && func_result[3]) |=> !digital_output[3];
	endproperty
	a_polarity: assert property (p_polarity) else $error("polarity not applied");

	property p_op_sample;
		@(posedge clk) disable iff (!reset_n)
		link_operational_state ##1 reset_n |-> op_r;
	endproperty
	a_op_sample: assert property (p_op_sample) else $error("op flag not sampled");

	// reset leaves every terminal off and the select cleared
	property p_reset_state;
		@(posedge clk)
		!reset_n |=> (sel_r == DOSR_SRC_SEL_RST) && (digital_output == '0);
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

	property p_mask_range;
		@(posedge clk) disable iff (!reset_n)
		(param_wr.valid && !param_wr.to_forced && param_wr.addr == DOSR_ADDR_NONOP_MASK)
		|=> (mask_r == ($past(param_wr.data) <= DOSR_VALUE_MAX ? $past(param_wr.data)
			: $past(mask_r))) && (wr_rejected_r == ($past(param_wr.data) > DOSR_VALUE_MAX));
	endproperty
	a_mask_range: assert property (p_mask_range) else $error("mask write wrong");

	property p_forced_comm;
		@(posedge clk) disable iff (!reset_n)
		(param_wr.valid && param_wr.to_forced && param_wr.from_comm)
		|=> (forced_r == $past(param_wr.data)) && !wr_rejected_r;
	endproperty
	a_forced_comm: assert property (p_forced_comm) else $error("host forced write lost");

	// non-forced writes to no known register are rejected and change neither select nor mask
	property p_addr_unknown;
		@(posedge clk) disable iff (!reset_n)
		(param_wr.valid && !param_wr.to_forced && param_wr.addr != DOSR_ADDR_SRC_SEL
			&& param_wr.addr != DOSR_ADDR_NONOP_MASK)
		|=> wr_rejected_r && $stable(sel_r) && $stable(mask_r);
	endproperty
	a_addr_unknown: assert property (p_addr_unknown) else $error("unknown write taken");

	property p_idle_reject;
		@(posedge clk) disable iff (!reset_n)
		!param_wr.valid |=> !wr_rejected_r;
	endproperty
	a_idle_reject: assert property (p_idle_reject) else $error("spurious reject");

	property p_rd_sel;
		@(posedge clk) disable iff (!reset_n)
		(rd_addr == DOSR_ADDR_SRC_SEL) |=> rd_data_r == $past(sel_r);
	endproperty
	a_rd_sel: assert property (p_rd_sel) else $error("select read wrong");

	property p_rd_mask;
		@(posedge clk) disable iff (!reset_n)
		(rd_addr == DOSR_ADDR_NONOP_MASK) |=> rd_data_r == $past(mask_r);
	endproperty
	a_rd_mask: assert property (p_rd_mask) else $error("mask read wrong");

	// every terminal, not only the sampled ones above
	generate
		for (n = 0; n < N_OUT; n++) begin : g_chk
			property p_route_bit;
				@(posedge clk) disable iff (!reset_n)
				(!sel_r[n] || op_r) |=> digital_output[n] ==
					(($past(sel_r[n]) ? $past(forced_r[n]) : $past(func_result[n]))
					^ $past(polarity[n]));
			endproperty
			a_route_bit: assert property (p_route_bit) else $error("route wrong");

			property p_nonop_bit;
				@(posedge clk) disable iff (!reset_n)
				(sel_r[n] && !op_r) |=> digital_output[n] ==
					($past(mask_r[n]) ? DOSR_LEVEL_OFF : $past(digital_output[n]));
			endproperty
			a_nonop_bit: assert property (p_nonop_bit) else $error("non-op level wrong");
		end
	endgenerate

	c_forced: cover property (@(posedge clk) disable iff (!reset_n) sel_r[0] && op_r && forced_r[0]);
	c_hold: cover property (@(posedge clk) disable iff (!reset_n) sel_r[1] && !op_r && !mask_r[1]);
	c_reject: cover property (@(posedge clk) disable iff (!reset_n) wr_rejected_r);
	c_nonop_off: cover property (@(posedge clk) disable iff (!reset_n)
		sel_r[0] && !op_r && mask_r[0]);
	c_mixed: cover property (@(posedge clk) disable iff (!reset_n)
		sel_r[0] && !sel_r[1] && op_r);
endmodule // dosr_router

// *** test/dosr_host.sv ***
// host model: link writes to the router and the operational flag
// assumes requests launched just after rising clk edges
`timescale 1ns/10ps
module dosr_host import dosr_pkg::*; (
	// clock
	input wire logic clk,
	// link side
	output dosr_wr_type param_wr,
	output logic link_operational_state
);
	initial begin
		param_wr = '0;
		link_operational_state = 1'b1;
	end
	task automatic wr(input logic c, f, input logic [15:0] a, d);
		@(posedge clk);
		param_wr <= '{1'b1, c, f, a, d};
		@(posedge clk);
		param_wr <= '{1'b0, ~c, ~f, ~a, ~d};
	endtask
	task automatic op(input logic v);
		@(posedge clk);
		link_operational_state <= v;
	endtask
endmodule // dosr_host

// *** test/digital_output_source_router_test.sv ***
// self-checking bench for the output source router
// assumes the host model issues writes and the link flag
`timescale 1ns/10ps
module digital_output_source_router_test import dosr_pkg::*; ;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [15:0] rd_addr = 16'h0000;
	logic [4:0] func_result = 5'h00;
	logic [4:0] polarity = 5'h00;
	logic [15:0] rd_data_r;
	logic wr_rejected_r;
	logic link_operational_state;
	logic [4:0] digital_output;
	dosr_wr_type param_wr;
	int error_cnt = 0;
	int checks = 0;
	always #4 clk = ~clk;
	dosr_host host_u (.clk(clk), .param_wr(param_wr),
		.link_operational_state(link_operational_state));
	dosr_router dut_u (.clk(clk), .reset_n(reset_n), .param_wr(param_wr), .rd_addr(rd_addr),
		.rd_data_r(rd_data_r), .wr_rejected_r(wr_rejected_r), .func_result(func_result),
		.polarity(polarity), .link_operational_state(link_operational_state),
		.digital_output(digital_output));
	task automatic chk(input string n, input logic [15:0] e, g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
		@(posedge clk);
	endtask
	task automatic out(input logic [4:0] e);
		repeat (3) @(posedge clk);
		#1;
		chk("out", {11'h000, e}, {11'h000, digital_output});
	endtask
	task automatic rd(input logic [15:0] a, e);
		@(posedge clk);
		rd_addr <= a;
		@(posedge clk);
		#1;
		chk("rd", e, rd_data_r);
	endtask
	task automatic wrc(input logic c, f, input logic [15:0] a, d, input logic r);
		host_u.wr(c, f, a, d);
		#1;
		chk("rej", {15'h0000, r}, {15'h0000, wr_rejected_r});
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		rd(DOSR_ADDR_SRC_SEL, DOSR_SRC_SEL_RST);
		rd(DOSR_ADDR_NONOP_MASK, DOSR_NONOP_MASK_RST);
		rd(16'h0418, DOSR_RD_UNMAPPED);
		func_result <= 5'h15;
		out(5'h15);
		polarity <= 5'h03;
		out(5'h16);
		$display("function route done");
		wrc(1'b0, 1'b0, DOSR_ADDR_SRC_SEL, 16'h001F, 1'b0);
		wrc(1'b0, 1'b0, DOSR_ADDR_SRC_SEL, 16'h0020, 1'b1);
		rd(DOSR_ADDR_SRC_SEL, DOSR_VALUE_MAX);
		wrc(1'b0, 1'b1, 16'h0000, 16'h000A, 1'b1);
		out(5'h03);
		wrc(1'b1, 1'b1, 16'h0000, 16'h000A, 1'b0);
		out(5'h09);
		$display("forced route done");
		wrc(1'b0, 1'b0, DOSR_ADDR_NONOP_MASK, 16'h0020, 1'b1);
		wrc(1'b1, 1'b0, DOSR_ADDR_NONOP_MASK, 16'h0005, 1'b0);
		wrc(1'b1, 1'b1, 16'h0000, 16'h001F, 1'b0);
		polarity <= 5'h00;
		out(5'h1F);
		host_u.op(1'b0);
		out(5'h1A);
		wrc(1'b1, 1'b1, 16'h0000, 16'h0000, 1'b0);
		out(5'h1A);
		host_u.op(1'b1);
		out(5'h00);
		$display("non-operational done");
		wrc(1'b0, 1'b0, DOSR_ADDR_SRC_SEL, 16'h0005, 1'b0);
		out(5'h10);
		rd(DOSR_ADDR_NONOP_MASK, 16'h0005);
		wrc(1'b0, 1'b0, 16'h0418, 16'h0001, 1'b1);
		rd(DOSR_ADDR_SRC_SEL, 16'h0005);
		$display("mixed route done");
		test_done();
	end
endmodule // digital_output_source_router_test
